// ---- verilog/sci_tx_pkg.sv ----
// Package with register map, field positions, reset values and carrier types for the serial transmitter.
package sci_tx_pkg;

   // Register indices; each register is one word, so its byte address is four times the index.
   localparam logic [7:0] IDX_CONTROL_ONE = 8'h13;
   localparam logic [7:0] IDX_CONTROL_TWO = 8'h14;
   localparam logic [7:0] IDX_CONTROL_THREE = 8'h15;
   localparam logic [7:0] IDX_STATUS_ONE = 8'h16;
   localparam logic [7:0] IDX_STATUS_TWO = 8'h17;
   localparam logic [7:0] IDX_DATA_BUFFER = 8'h18;
   localparam logic [7:0] IDX_BAUD_RATE = 8'h19;
   // The spare word sits just after the baud rate register.
   localparam logic [7:0] IDX_RX_EVENT = 8'h1a;
   // Register byte addresses on the APB slave.
   localparam logic [7:0] ADDR_CONTROL_ONE = {IDX_CONTROL_ONE[5:0], 2'b00};
   localparam logic [7:0] ADDR_CONTROL_TWO = {IDX_CONTROL_TWO[5:0], 2'b00};
   localparam logic [7:0] ADDR_CONTROL_THREE = {IDX_CONTROL_THREE[5:0], 2'b00};
   localparam logic [7:0] ADDR_STATUS_ONE = {IDX_STATUS_ONE[5:0], 2'b00};
   localparam logic [7:0] ADDR_STATUS_TWO = {IDX_STATUS_TWO[5:0], 2'b00};
   localparam logic [7:0] ADDR_DATA_BUFFER = {IDX_DATA_BUFFER[5:0], 2'b00};
   localparam logic [7:0] ADDR_BAUD_RATE = {IDX_BAUD_RATE[5:0], 2'b00};
   localparam logic [7:0] ADDR_RX_EVENT = {IDX_RX_EVENT[5:0], 2'b00};

   // Field positions in control register one.
   localparam int C1_INVERT = 5;
   localparam int C1_ENABLE = 6;
   localparam int C1_LENGTH = 4;
   // Field positions in control register two.
   localparam int C2_EMPTY_IE = 7;
   localparam int C2_COMPLETE_IE = 6;
   localparam int C2_TX_ENABLE = 3;
   localparam int C2_BREAK = 0;
   // Field positions in control register three.
   localparam int C3_RX_NINTH = 7;
   localparam int C3_TX_NINTH = 6;
   // Field positions in status registers.
   localparam int S1_EMPTY = 7;
   localparam int S1_COMPLETE = 6;
   localparam int S1_RX_FULL = 5;
   localparam int S1_FRAMING = 1;
   localparam int S2_BREAK = 1;
   // Field position in the baud rate register.
   localparam int BR_EXT_BREAK = 6;

   // Reset values.
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [7:0] RESET_STATUS_ONE = 8'hc0;

   // Bit period in receiver sample clocks, and the divider for one sample clock.
   localparam int SAMPLES_PER_BIT = 16;
   localparam logic [3:0] HALF_BIT_SAMPLES = 4'h8;
   localparam logic [7:0] SAMPLE_DIV_RESET = 8'h00;

   // Character kinds held in the shift register.
   typedef enum logic [1:0] {KIND_NONE, KIND_DATA, KIND_IDLE, KIND_BREAK} kind_t;

   // APB request carrier.
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } apb_req_t;

endpackage

// ---- verilog/sci_tx.sv ----
// Serial transmitter with break and idle generation, received-break register effects and APB slave.
// How it works
// - Character length bit picks 8 or 9 data bits; ninth from tx_ninth_bit.
// - A transmission opens with an idle preamble before buffered data loads.
// - Data characters get a zero start bit first and a one stop bit last.
// - Buffer-empty flag sets when data moves into the shift register; may interrupt.
// - Line rests at idle level whenever no character is shifting.
// - Clearing module enable releases the transmit pin at once.
// - Send-break loads all-zero break characters sized by length and extended-break bits.
// - Breaks repeat while send-break holds; afterwards at least one one bit follows.
// - Received break is 10/11 zeros, or 11/12 with extended-break selected.
// - Received break sets framing, full and break flags, clears data and ninth bit.
// - Idle characters are all ones sized by the character length bit.
// - Clearing transmitter enable finishes the current character before idling.
// - Clearing then setting transmitter enable queues one idle character next.
// - Break followed directly by idle loses half a bit at its end.
// - Output inversion inverts every transmitted level.
// - Complete flag means buffer and shifter empty and no break or idle pending.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module sci_tx
   import sci_tx_pkg::*;
(
   input wire logic clock, // System clock, 40 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire logic [7:0] sample_div, // Clocks per receiver sample clock minus one.
   input wire logic rx_break_seen, // Pulse from the receiver when it sees a break.
   input wire logic [3:0] rx_zero_count_limit, // Unused by the transmitter path.
   output logic txd_out, // Transmit data level.
   output logic txd_oe, // High while the transmitter owns the pin.
   output logic tx_irq // Transmitter interrupt request.
);

   // Reset release through two flip-flops.
   logic rst_sync_a_ff;
   logic rst_sync_ff;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_a_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_sync_a_ff <= 1'b1;
         rst_sync_ff <= rst_sync_a_ff;
      end
   end

   apb_req_t req;
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

   logic [7:0] ctl_one_ff;
   logic [7:0] ctl_two_ff;
   logic tx_ninth_bit_ff;
   logic rx_ninth_bit_ff;
   logic [7:0] baud_rate_reg_ff;
   logic [7:0] data_buffer_reg_ff;
   logic [7:0] rx_data_ff;
   logic tx_buffer_empty_flag_ff;
   logic tx_complete_flag_ff;
   logic rx_full_flag_ff;
   logic framing_error_flag_ff;
   logic break_flag_ff;
   logic status_read_ff;
   logic idle_queued_ff;

   // Shifter state.
   logic [12:0] shift_ff;
   logic [3:0] bits_left_ff;
   kind_t kind_ff;
   logic [7:0] div_ff;
   logic [3:0] sample_ff;
   logic need_preamble_ff;
   logic need_one_ff;

   logic module_enable;
   logic transmitter_enable;
   logic send_break_bit;
   logic nine_bits;
   logic tx_output_invert;
   logic extended_break_select;
   assign module_enable = ctl_one_ff[C1_ENABLE];
   assign transmitter_enable = ctl_two_ff[C2_TX_ENABLE];
   assign send_break_bit = ctl_two_ff[C2_BREAK];
   assign nine_bits = ctl_one_ff[C1_LENGTH];
   assign tx_output_invert = ctl_one_ff[C1_INVERT];
   assign extended_break_select = baud_rate_reg_ff[BR_EXT_BREAK];

   logic acc;
   logic wr;
   logic rd;
   assign acc = req.sel && req.enable;
   assign wr = acc && req.write;
   assign rd = acc && !req.write;

   // Character length helpers: data frame and break lengths.
   function automatic logic [3:0] frame_bits(input logic nine);
      frame_bits = nine ? 4'hb : 4'ha;
   endfunction
   function automatic logic [3:0] break_bits(input logic nine, input logic ext);
      break_bits = frame_bits(nine) + (ext ? 4'h1 : 4'h0);
   endfunction

   // Bit and sample timing from the shared divider.
   logic sample_tick;
   logic bit_tick;
   logic half_tick;
   logic busy;
   assign sample_tick = (div_ff == sample_div);
   assign bit_tick = sample_tick && (sample_ff == 4'(SAMPLES_PER_BIT - 1));
   assign half_tick = sample_tick && (sample_ff == HALF_BIT_SAMPLES - 4'h1);
   assign busy = (kind_ff != KIND_NONE);

   logic last_bit;
   logic cut_break;
   assign last_bit = busy && (bits_left_ff == 4'h1);
   // A break whose successor is a queued idle ends half a bit early.
   assign cut_break = last_bit && (kind_ff == KIND_BREAK) && !send_break_bit
      && idle_queued_ff && half_tick;
   logic char_done;
   assign char_done = (last_bit && bit_tick) || cut_break;

   // The next character chosen when the shifter frees up.
   logic load_break;
   logic load_one;
   logic load_idle;
   logic load_data;
   logic can_load;
   assign can_load = module_enable && (!busy || char_done);
   // Breaks reload back to back; the trailing one only follows once send-break is clear.
   assign load_break = can_load && send_break_bit && !idle_queued_ff;
   assign load_one = can_load && !load_break && need_one_ff && !idle_queued_ff;
   assign load_idle = can_load && transmitter_enable && !load_break && !load_one
      && (need_preamble_ff || idle_queued_ff);
   assign load_data = can_load && transmitter_enable && !load_break && !load_one
      && !load_idle && !tx_buffer_empty_flag_ff;

   // Sample clock divider and sample position; restart with each new character.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         div_ff <= SAMPLE_DIV_RESET;
         sample_ff <= 4'h0;
      end else if (!busy || load_break || load_one || load_idle || load_data) begin
         div_ff <= SAMPLE_DIV_RESET;
         sample_ff <= 4'h0;
      end else begin
         div_ff <= sample_tick ? SAMPLE_DIV_RESET : div_ff + 8'h01;
         if (sample_tick) begin
            sample_ff <= sample_ff + 4'h1;
         end
      end
   end

   // Shift register and character kind.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         shift_ff <= '1;
         bits_left_ff <= 4'h0;
         kind_ff <= KIND_NONE;
      end else if (!module_enable) begin
         shift_ff <= '1;
         bits_left_ff <= 4'h0;
         kind_ff <= KIND_NONE;
      end else if (load_break) begin
         shift_ff <= '0;
         bits_left_ff <= break_bits(nine_bits, extended_break_select);
         kind_ff <= KIND_BREAK;
      end else if (load_one) begin
         shift_ff <= '1;
         bits_left_ff <= 4'h1;
         kind_ff <= KIND_IDLE;
      end else if (load_idle) begin
         shift_ff <= '1;
         bits_left_ff <= frame_bits(nine_bits);
         kind_ff <= KIND_IDLE;
      end else if (load_data) begin
         // Start bit in the low position, stop bit at the top of the frame.
         shift_ff <= nine_bits ? {3'b111, tx_ninth_bit_ff, data_buffer_reg_ff, 1'b0}
            : {3'b111, 1'b1, data_buffer_reg_ff, 1'b0};
         bits_left_ff <= frame_bits(nine_bits);
         kind_ff <= KIND_DATA;
      end else if (char_done) begin
         kind_ff <= KIND_NONE;
         bits_left_ff <= 4'h0;
         shift_ff <= '1;
      end else if (busy && bit_tick) begin
         shift_ff <= {1'b1, shift_ff[12:1]};
         bits_left_ff <= bits_left_ff - 4'h1;
      end
   end

   // Preamble, trailing one and queued idle bookkeeping.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         need_preamble_ff <= 1'b1;
         need_one_ff <= 1'b0;
         idle_queued_ff <= 1'b0;
      end else begin
         if (!module_enable || !transmitter_enable) begin
            need_preamble_ff <= 1'b1;
         end else if (load_idle) begin
            need_preamble_ff <= 1'b0;
         end
         if (load_break) begin
            need_one_ff <= 1'b1;
         end else if (load_one || load_idle || load_data) begin
            need_one_ff <= 1'b0;
         end
         if (!module_enable) begin
            idle_queued_ff <= 1'b0;
         end else if (busy && wr && req.addr == ADDR_CONTROL_TWO && !transmitter_enable
            && req.wdata[C2_TX_ENABLE]) begin
            idle_queued_ff <= 1'b1;
         end else if (load_idle) begin
            idle_queued_ff <= 1'b0;
         end
      end
   end

   // Control registers and transmit data buffer writes.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         ctl_one_ff <= RESET_CONTROL;
         ctl_two_ff <= RESET_CONTROL;
         baud_rate_reg_ff <= RESET_CONTROL;
         tx_ninth_bit_ff <= 1'b0;
         data_buffer_reg_ff <= 8'h00;
      end else if (wr) begin
         unique case (req.addr)
            ADDR_CONTROL_ONE: ctl_one_ff <= req.wdata[7:0];
            ADDR_CONTROL_TWO: ctl_two_ff <= req.wdata[7:0];
            ADDR_CONTROL_THREE: tx_ninth_bit_ff <= req.wdata[C3_TX_NINTH];
            ADDR_BAUD_RATE: baud_rate_reg_ff <= req.wdata[7:0];
            ADDR_DATA_BUFFER: data_buffer_reg_ff <= req.wdata[7:0];
            default: ;
         endcase
      end
   end

   // Empty flag: cleared by status read then data write; a transfer wins the same cycle.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         tx_buffer_empty_flag_ff <= RESET_STATUS_ONE[S1_EMPTY];
         status_read_ff <= 1'b0;
      end else begin
         if (rd && req.addr == ADDR_STATUS_ONE) begin
            status_read_ff <= 1'b1;
         end else if (wr && req.addr == ADDR_DATA_BUFFER) begin
            status_read_ff <= 1'b0;
         end
         if (load_data) begin
            tx_buffer_empty_flag_ff <= 1'b1;
         end else if (wr && req.addr == ADDR_DATA_BUFFER && status_read_ff) begin
            tx_buffer_empty_flag_ff <= 1'b0;
         end
      end
   end

   // Complete flag tracks idle shifter, empty buffer and nothing pending.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         tx_complete_flag_ff <= RESET_STATUS_ONE[S1_COMPLETE];
      end else begin
         tx_complete_flag_ff <= !busy && tx_buffer_empty_flag_ff && !send_break_bit
            && !idle_queued_ff && !need_one_ff;
      end
   end

   // Received break effects; a break wins over a clearing read in the same cycle.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rx_full_flag_ff <= 1'b0;
         framing_error_flag_ff <= 1'b0;
         break_flag_ff <= 1'b0;
         rx_data_ff <= 8'h00;
         rx_ninth_bit_ff <= 1'b0;
      end else if (rx_break_seen) begin
         rx_full_flag_ff <= 1'b1;
         framing_error_flag_ff <= 1'b1;
         break_flag_ff <= 1'b1;
         rx_data_ff <= 8'h00;
         rx_ninth_bit_ff <= 1'b0;
      end else if (rd && req.addr == ADDR_DATA_BUFFER) begin
         rx_full_flag_ff <= 1'b0;
         framing_error_flag_ff <= 1'b0;
         break_flag_ff <= 1'b0;
      end
   end

   // Read data mux.
   logic [31:0] nxt_prdata;
   logic nxt_err;
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      nxt_err = 1'b0;
      unique case (req.addr)
         ADDR_CONTROL_ONE: nxt_prdata[7:0] = ctl_one_ff;
         ADDR_CONTROL_TWO: nxt_prdata[7:0] = ctl_two_ff;
         ADDR_CONTROL_THREE: nxt_prdata[7:0] = {rx_ninth_bit_ff, tx_ninth_bit_ff, 6'h00};
         ADDR_STATUS_ONE: begin
            nxt_prdata[S1_EMPTY] = tx_buffer_empty_flag_ff;
            nxt_prdata[S1_COMPLETE] = tx_complete_flag_ff;
            nxt_prdata[S1_RX_FULL] = rx_full_flag_ff;
            nxt_prdata[S1_FRAMING] = framing_error_flag_ff;
         end
         ADDR_STATUS_TWO: nxt_prdata[S2_BREAK] = break_flag_ff;
         ADDR_DATA_BUFFER: nxt_prdata[7:0] = rx_data_ff;
         ADDR_BAUD_RATE: nxt_prdata[7:0] = baud_rate_reg_ff;
         ADDR_RX_EVENT: nxt_prdata[3:0] = rx_zero_count_limit;
         default: nxt_err = 1'b1;
      endcase
   end

   // APB answer: registered, no wait states per access.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= req.sel && !req.enable;
         prdata <= nxt_prdata;
         pslverr <= req.sel && !req.enable && nxt_err;
      end
   end

   // Pin drive, inversion and interrupt request.
   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         txd_out <= 1'b1;
         txd_oe <= 1'b0;
         tx_irq <= 1'b0;
      end else begin
         txd_out <= (busy ? shift_ff[0] : 1'b1) ^ tx_output_invert;
         txd_oe <= module_enable;
         tx_irq <= (tx_buffer_empty_flag_ff && ctl_two_ff[C2_EMPTY_IE])
            || (tx_complete_flag_ff && ctl_two_ff[C2_COMPLETE_IE]);
      end
   end

endmodule // sci_tx

// ---- sim/sci_tx_assertions.sv ----
// Port checker for the serial transmitter, bound into it.
`timescale 1ns/1ps
module sci_tx_checker
   import sci_tx_pkg::*;
(
   input wire logic clock, // Clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic psel, // Select.
   input wire logic penable, // Access phase.
   input wire logic pwrite, // Write.
   input wire logic [7:0] paddr, // Address.
   input wire logic [31:0] pwdata, // Write data.
   input wire logic [31:0] prdata, // Read data.
   input wire logic pready, // Ready.
   input wire logic pslverr, // Error.
   input wire logic txd_out, // Line.
   input wire logic txd_oe // Pin owned.
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // The slave adds no wait states and answers once per transfer.
   a_ready_on_access: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   // Refused reads return zero, so stale data never leaks out.
   a_error_reads_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("error outside an answer or with data");
   a_unmapped_refused: assert property (pready && paddr > ADDR_RX_EVENT |-> pslverr)
      else $error("unmapped access accepted");
   a_mapped_accepted: assert property
      (pready && paddr >= ADDR_CONTROL_ONE && paddr <= ADDR_RX_EVENT && paddr[1:0] == 2'h0
      |-> !pslverr)
      else $error("mapped access refused");
   // The enable lands at the answer and the pin flop follows one clock later.
   a_pin_claimed: assert property
      (pready && pwrite && paddr == ADDR_CONTROL_ONE && pwdata[C1_ENABLE] |-> ##[1:2] txd_oe)
      else $error("pin not claimed");
   a_pin_released: assert property
      (pready && pwrite && paddr == ADDR_CONTROL_ONE && !pwdata[C1_ENABLE] |-> ##[1:2] !txd_oe)
      else $error("pin not released");
   // Even a cut break keeps half a bit, eight clocks at sixteen a bit.
   a_bit_hold: assert property (txd_oe && $changed(txd_out) |=> $stable(txd_out) [*7])
      else $error("line level too short");
endmodule // sci_tx_checker
bind sci_tx sci_tx_checker i_sci_tx_checker (.clock(clock), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .txd_out(txd_out), .txd_oe(txd_oe));

// ---- sim/sci_line_receiver.sv ----
// Far-end receiver model: decodes the line and times long zero runs.
`timescale 1ns/1ps
module sci_line_receiver #(
   parameter int BIT_CLOCKS = 16 // Clocks per bit.
) (
   input wire logic clock, // Clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic line, // Line level at the far end.
   input wire logic inv, // Levels are inverted.
   input wire logic nine, // Nine data bits.
   output logic [8:0] data_ff, // Last character.
   output logic stop_ff, // Its stop level.
   output int frames_ff, // Characters with a good stop bit.
   output int zero_run_ff // Last zero run of 100 clocks or more.
);
   logic lvl;
   logic prev_ff;
   logic busy_ff;
   int cnt_ff;
   int zrun_ff;
   int k;
   assign lvl = line ^ inv;
   assign k = cnt_ff / BIT_CLOCKS;
   // Starts only on a falling edge, so a long break cannot retrigger it.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= 1'h1;
         busy_ff <= 1'h0;
         cnt_ff <= 0;
         frames_ff <= 0;
         data_ff <= 9'h000;
         stop_ff <= 1'h0;
      end else begin
         prev_ff <= lvl;
         cnt_ff <= cnt_ff + 1;
         if (!busy_ff) begin
            busy_ff <= prev_ff && !lvl;
            cnt_ff <= 1;
         end else if (cnt_ff % BIT_CLOCKS == BIT_CLOCKS / 2) begin
            if (k == 0 && lvl) busy_ff <= 1'h0;
            else if (k == 1) data_ff <= {8'h00, lvl};
            else if (k <= (nine ? 9 : 8)) data_ff[k - 1] <= lvl;
            else begin
               stop_ff <= lvl;
               frames_ff <= frames_ff + (lvl ? 1 : 0);
               busy_ff <= 1'h0;
            end
         end
      end
   end
   // Long zero runs are breaks; their length in clocks is kept.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         zrun_ff <= 0;
         zero_run_ff <= 0;
      end else if (!lvl) begin
         zrun_ff <= zrun_ff + 1;
      end else begin
         zrun_ff <= 0;
         if (zrun_ff >= 100) zero_run_ff <= zrun_ff;
      end
   end
endmodule // sci_line_receiver

// ---- sim/async_serial_transmitter_break_bench.sv ----
// Self-checking bench for the serial transmitter.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("Error %s expected %h seen %h", n, (e), (g)); \
   end \
end
module async_serial_transmitter_break_bench
   import sci_tx_pkg::*;
;
   localparam int BIT = 16;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic rx_break_seen = 1'h0;
   logic inv_m = 1'h0;
   logic nine_m = 1'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, txd_out, txd_oe, tx_irq, rerr, got_stop;
   logic [8:0] got_data;
   int got_frames, zero_run;
   int frames_exp = 0;
   int errors = 0;
   int comparisons = 0;
   always #12.5 clock = ~clock;
   // Sample clock divider tied to zero keeps a bit at sixteen clocks.
   sci_tx i_sci_tx (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_div(8'h00), .rx_break_seen(rx_break_seen),
      .rx_zero_count_limit(4'h3), .txd_out(txd_out), .txd_oe(txd_oe), .tx_irq(tx_irq));
   sci_line_receiver #(.BIT_CLOCKS(BIT)) i_sci_line_receiver (.clock(clock), .rst_n(rst_n),
      .line(txd_oe ? txd_out : 1'h1), .inv(inv_m), .nine(nine_m), .data_ff(got_data),
      .stop_ff(got_stop),
      .frames_ff(got_frames), .zero_run_ff(zero_run));
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // One bus transfer; the answer is taken at the edge that sees ready.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic wait_frame();
      int n;
      n = 0;
      frames_exp++;
      while (got_frames != frames_exp && n < 4000) begin
         @(posedge clock);
         n++;
      end
      `CHK("frames", frames_exp, got_frames)
      if (n >= 4000) tally_and_finish();
   endtask
   task automatic t_regs();
      apb(1'h0, ADDR_STATUS_ONE, 32'h0);
      `CHK("status reset", {24'h0, RESET_STATUS_ONE}, rdat)
      apb(1'h0, ADDR_RX_EVENT + 8'h04, 32'h0);
      `CHK("unmapped error", 1'h1, rerr)
      apb(1'h0, ADDR_RX_EVENT, 32'h0);
      `CHK("spare", 32'h3, rdat)
      $display("regs done");
   endtask
   task automatic t_frame(input logic len9, input logic inv, input logic [8:0] d);
      apb(1'h1, ADDR_CONTROL_ONE, {24'h0, 2'h1, inv, len9, 4'h0});
      inv_m <= inv;
      nine_m <= len9;
      apb(1'h1, ADDR_CONTROL_TWO, 32'hc8);
      apb(1'h0, ADDR_STATUS_ONE, 32'h0);
      apb(1'h1, ADDR_CONTROL_THREE, {24'h0, 1'h0, d[8], 6'h0});
      apb(1'h1, ADDR_DATA_BUFFER, {24'h0, d[7:0]});
      repeat (100) @(posedge clock);
      `CHK("preamble", 1'h1, txd_out ^ inv)
      wait_frame();
      `CHK("data", d & (len9 ? 9'h1ff : 9'h0ff), got_data)
      `CHK("stop", 1'h1, got_stop)
      repeat (BIT) @(posedge clock);
      `CHK("irq", 1'h1, tx_irq)
      apb(1'h0, ADDR_STATUS_ONE, 32'h0);
      `CHK("empty complete", 2'h3, rdat[7:6])
      apb(1'h1, ADDR_CONTROL_TWO, 32'h0);
      $display("frame done");
   endtask
   // Break, then either data queued in time or an idle queued by a toggle.
   task automatic t_break(input logic ext, input logic idle);
      int n;
      n = 0;
      apb(1'h1, ADDR_BAUD_RATE, {25'h0, ext, 6'h0});
      apb(1'h1, ADDR_CONTROL_ONE, 32'h40);
      inv_m <= 1'h0;
      nine_m <= 1'h0;
      // A polarity change is not a bit, so let the line settle before the break starts.
      repeat (BIT) @(posedge clock);
      apb(1'h1, ADDR_CONTROL_TWO, 32'h09);
      while (txd_out !== 1'h0 && n < 1000) begin
         @(posedge clock);
         n++;
      end
      `CHK("break start", 1'h0, txd_out)
      if (n >= 1000) tally_and_finish();
      // The extended case holds send-break into a second break, which must follow at once.
      repeat (ext ? 12 * BIT : 2 * BIT) @(posedge clock);
      if (idle) begin
         apb(1'h1, ADDR_CONTROL_TWO, 32'h0);
         apb(1'h1, ADDR_CONTROL_TWO, 32'h08);
         repeat (20 * BIT) @(posedge clock);
         `CHK("short break", 10 * BIT - BIT / 2, zero_run)
      end else begin
         apb(1'h0, ADDR_STATUS_ONE, 32'h0);
         apb(1'h1, ADDR_DATA_BUFFER, 32'h5a);
         apb(1'h1, ADDR_CONTROL_TWO, 32'h08);
         wait_frame();
         `CHK("break length", BIT * (10 + ext) * (ext ? 2 : 1), zero_run)
         `CHK("data after break", 9'h05a, got_data)
      end
      apb(1'h1, ADDR_CONTROL_TWO, 32'h0);
      $display("break done");
   endtask
   task automatic t_rxbrk();
      @(posedge clock);
      rx_break_seen <= 1'h1;
      @(posedge clock);
      rx_break_seen <= 1'h0;
      apb(1'h0, ADDR_STATUS_ONE, 32'h0);
      `CHK("full framing", 2'h3, {rdat[S1_RX_FULL], rdat[S1_FRAMING]})
      apb(1'h0, ADDR_STATUS_TWO, 32'h0);
      `CHK("break flag", 1'h1, rdat[S2_BREAK])
      apb(1'h0, ADDR_CONTROL_THREE, 32'h0);
      `CHK("rx ninth", 1'h0, rdat[C3_RX_NINTH])
      apb(1'h0, ADDR_DATA_BUFFER, 32'h0);
      `CHK("rx data", 32'h0, rdat)
      apb(1'h0, ADDR_STATUS_ONE, 32'h0);
      `CHK("full cleared", 2'h0, {rdat[S1_RX_FULL], rdat[S1_FRAMING]})
      apb(1'h1, ADDR_CONTROL_ONE, 32'h0);
      repeat (2) @(posedge clock);
      `CHK("pin released", 1'h0, txd_oe)
      $display("rx break done");
   endtask
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      repeat (3) @(posedge clock);
      t_regs();
      t_frame(1'h0, 1'h0, 9'h0a5);
      t_frame(1'h1, 1'h1, 9'h13c);
      t_break(1'h0, 1'h0);
      t_break(1'h1, 1'h0);
      t_break(1'h0, 1'h1);
      t_rxbrk();
      tally_and_finish();
   end
endmodule // async_serial_transmitter_break_bench
